// File: shared/qpsl_defs.svh
`ifndef QPSL_DEFS_SVH
`define QPSL_DEFS_SVH
// ----------------------------------------
// channel count
// ----------------------------------------
`define QPSL_NCH 4
// ----------------------------------------
// modem control register bit positions
// ----------------------------------------
`define QPSL_MCTL_DTR 0
`define QPSL_MCTL_RTS 1
`define QPSL_MCTL_INTEN 3
`define QPSL_MCTL_IR 6
// ----------------------------------------
// enhanced feature register bit positions
// ----------------------------------------
`define QPSL_FEAT_ARTS 6
`define QPSL_FEAT_ACTS 7
// ----------------------------------------
// interrupt enable register bit positions
// ----------------------------------------
`define QPSL_IEN_RTSI 6
`define QPSL_IEN_CTSI 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define QPSL_RST_TX 4'hF
`define QPSL_RST_IR_TX 4'h0
`define QPSL_RST_RDY 4'hF
`define QPSL_RST_INT 4'h0
`define QPSL_RST_INT_OE 4'h0
`define QPSL_RST_MODEM_N 4'hF
`define QPSL_RST_BYTE 8'h00
`define QPSL_RST_BUSSEL 1'h1
`define QPSL_RST_ISEL 1'h0
`define QPSL_RST_FSS_N 1'h1
`define QPSL_RST_CTS_N 4'hF
`endif

// File: shared/qpsl_pkg.sv
// ----------------------------------------
// shared types
// ----------------------------------------
package qpsl_pkg;
  // host bus flavour chosen by the bus select pin
  typedef enum logic {
    QPSL_BUS_SPLIT,
    QPSL_BUS_RWLINE
  } qpsl_bus_mode_t;
endpackage

// File: rtl/qpsl_top.sv
`timescale 1ns/100ps
`include "qpsl_defs.svh"

module qpsl_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // strap and select pins, asynchronous
  input wire logic bus_sel_in,
  input wire logic interrupt_select_in,
  input wire logic fifo_status_select_n,
  // channel registers from the uart cores
  input wire logic [3:0][7:0] modem_control_reg,
  input wire logic [3:0][7:0] enhanced_feature_reg,
  input wire logic [3:0][7:0] interrupt_enable_reg,
  // channel state from the uart cores
  input wire logic [3:0] ch_irq,
  input wire logic [3:0] tx_space,
  input wire logic [3:0] rx_avail,
  input wire logic [3:0] tx_serial,
  input wire logic [3:0] tx_ir_enc,
  input wire logic [3:0] rts_halt,
  // clear-to-send pins, asynchronous
  input wire logic [3:0] cts_n_pin,
  // interrupt pins
  output logic [3:0] int_out,
  output logic [3:0] int_oe,
  // ready pins
  output logic [3:0] tx_ready_n,
  output logic [3:0] rx_ready_n,
  output logic tx_ready_all_n,
  output logic rx_ready_all_n,
  // status byte onto the host data bus
  output logic [7:0] data_out,
  output logic data_oe,
  // serial pins
  output logic [3:0] serial_tx_out,
  output logic [3:0] infrared_tx_out,
  output logic [3:0] rts_n_out,
  output logic [3:0] dtr_n_out,
  // flow control back to the cores
  output logic [3:0] cts_tx_allow,
  output logic [3:0] cts_gp_n,
  output logic [3:0] cts_stop_irq,
  output logic [3:0] rts_stop_irq
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic bsel_s1_q, bsel_s1_d; // first stage
  logic bsel_s2_q, bsel_s2_d; // clean bus select
  logic isel_s1_q, isel_s1_d;
  logic isel_s2_q, isel_s2_d; // clean interrupt select
  logic fss_s1_q, fss_s1_d;
  logic fss_s2_q, fss_s2_d; // clean status select
  logic [3:0] cts_s1_q, cts_s1_d;
  logic [3:0] cts_s2_q, cts_s2_d; // clean cts level
  logic [3:0] cts_s3_q, cts_s3_d; // previous clean level

  // next values: shift each chain by one
  always_comb begin
    bsel_s1_d = bus_sel_in;
    bsel_s2_d = bsel_s1_q;
    isel_s1_d = interrupt_select_in;
    isel_s2_d = isel_s1_q;
    fss_s1_d = fifo_status_select_n;
    fss_s2_d = fss_s1_q;
    cts_s1_d = cts_n_pin;
    cts_s2_d = cts_s1_q;
    cts_s3_d = cts_s2_q;
  end

  // reset values copy the pin pulls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bsel_s1_q <= `QPSL_RST_BUSSEL;
      bsel_s2_q <= `QPSL_RST_BUSSEL;
      isel_s1_q <= `QPSL_RST_ISEL;
      isel_s2_q <= `QPSL_RST_ISEL;
      fss_s1_q <= `QPSL_RST_FSS_N;
      fss_s2_q <= `QPSL_RST_FSS_N;
      cts_s1_q <= `QPSL_RST_CTS_N;
      cts_s2_q <= `QPSL_RST_CTS_N;
      cts_s3_q <= `QPSL_RST_CTS_N;
    end else begin
      bsel_s1_q <= bsel_s1_d;
      bsel_s2_q <= bsel_s2_d;
      isel_s1_q <= isel_s1_d;
      isel_s2_q <= isel_s2_d;
      fss_s1_q <= fss_s1_d;
      fss_s2_q <= fss_s2_d;
      cts_s1_q <= cts_s1_d;
      cts_s2_q <= cts_s2_d;
      cts_s3_q <= cts_s3_d;
    end
  end

  // ----------------------------------------
  // bus mode
  // ----------------------------------------
  qpsl_pkg::qpsl_bus_mode_t bus_mode; // decoded strap
  // high picks split strobes, low the rw line
  assign bus_mode = bsel_s2_q ? qpsl_pkg::QPSL_BUS_SPLIT
                              : qpsl_pkg::QPSL_BUS_RWLINE;

  // ----------------------------------------
  // per-channel decode
  // ----------------------------------------
  logic [3:0] int_en; // control bit3 per channel
  logic [3:0] ir_en; // control bit6 per channel
  logic [3:0] tx_d, rts_d, dtr_d, allow_d;
  logic [3:0] cstop_d, rstop_d;
  logic [3:0] txr_d, rxr_d; // ready, active low

  genvar g;
  generate
    for (g = 0; g < `QPSL_NCH; g++) begin : g_ch
      assign int_en[g] = modem_control_reg[g][`QPSL_MCTL_INTEN];
      assign ir_en[g] = modem_control_reg[g][`QPSL_MCTL_IR];
      // low while the holding side can take a byte
      assign txr_d[g] = ~tx_space[g];
      // low while a byte waits to be read
      assign rxr_d[g] = ~rx_avail[g];
      // infrared source idles low, plain source high
      assign tx_d[g] = ir_en[g] ? tx_ir_enc[g] : tx_serial[g];
      // auto flow may lift rts only when software set it
      assign rts_d[g] = ~(modem_control_reg[g][`QPSL_MCTL_RTS]
        & ~(enhanced_feature_reg[g][`QPSL_FEAT_ARTS] & rts_halt[g]));
      assign dtr_d[g] = ~modem_control_reg[g][`QPSL_MCTL_DTR];
      // cts high stops transmit only in auto mode
      assign allow_d[g] = ~(enhanced_feature_reg[g][`QPSL_FEAT_ACTS]
        & cts_s2_q[g]);
      // stop event: clean level rising while armed
      assign cstop_d[g] = enhanced_feature_reg[g][`QPSL_FEAT_ACTS]
        & interrupt_enable_reg[g][`QPSL_IEN_CTSI]
        & cts_s2_q[g] & ~cts_s3_q[g];
      // rts lifted by auto flow, reported if enabled
      assign rstop_d[g] = enhanced_feature_reg[g][`QPSL_FEAT_ARTS]
        & interrupt_enable_reg[g][`QPSL_IEN_RTSI]
        & modem_control_reg[g][`QPSL_MCTL_RTS] & rts_halt[g];
    end
  endgenerate

  // ----------------------------------------
  // pin output registers
  // ----------------------------------------
  logic [3:0] int_out_q, int_out_d;
  logic [3:0] int_oe_q, int_oe_d;
  logic [3:0] txr_q, rxr_q;
  logic txr_all_q, txr_all_d;
  logic rxr_all_q, rxr_all_d;
  logic [7:0] byte_q, byte_d;
  logic byte_oe_q, byte_oe_d;
  logic [3:0] tx_q, ir_tx_q, rts_q, dtr_q;
  logic [3:0] allow_q, gp_q, cstop_q, rstop_q;

  // next values of the interrupt and status pins
  always_comb begin
    int_out_d = ch_irq;
    int_oe_d = `QPSL_RST_INT_OE;
    case (bus_mode)
      qpsl_pkg::QPSL_BUS_SPLIT: begin
        // select high overrides the enable bits
        if (isel_s2_q) begin
          int_oe_d = 4'hF;
        end else begin
          // undriven unless bit3 set
          int_oe_d = int_en;
        end
      end
      qpsl_pkg::QPSL_BUS_RWLINE: begin
        // channel 0 is a shared open-drain request
        int_out_d = `QPSL_RST_INT;
        int_oe_d = {3'h7, |ch_irq};
      end
      default: begin
        int_oe_d = `QPSL_RST_INT_OE;
      end
    endcase
    // combined ready uses the next ready values
    txr_all_d = &txr_d;
    rxr_all_d = &rxr_d;
    // built from the same next values as the pins,
    // so the byte and the pins agree except in reset, which loads the byte with 00
    byte_d = {rxr_d, ~txr_d};
    // no address term: the select alone reads it
    byte_oe_d = ~fss_s2_q;
  end

  // all pins registered; tx idles high in reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_out_q <= `QPSL_RST_INT;
      int_oe_q <= `QPSL_RST_INT_OE;
      txr_q <= `QPSL_RST_RDY;
      rxr_q <= `QPSL_RST_RDY;
      txr_all_q <= 1'h1;
      rxr_all_q <= 1'h1;
      byte_q <= `QPSL_RST_BYTE;
      byte_oe_q <= 1'h0;
      tx_q <= `QPSL_RST_TX;
      ir_tx_q <= `QPSL_RST_IR_TX;
      rts_q <= `QPSL_RST_MODEM_N;
      dtr_q <= `QPSL_RST_MODEM_N;
      allow_q <= 4'hF;
      gp_q <= `QPSL_RST_CTS_N;
      cstop_q <= 4'h0;
      rstop_q <= 4'h0;
    end else begin
      int_out_q <= int_out_d;
      int_oe_q <= int_oe_d;
      txr_q <= txr_d;
      rxr_q <= rxr_d;
      txr_all_q <= txr_all_d;
      rxr_all_q <= rxr_all_d;
      byte_q <= byte_d;
      byte_oe_q <= byte_oe_d;
      tx_q <= tx_d;
      ir_tx_q <= tx_ir_enc;
      rts_q <= rts_d;
      dtr_q <= dtr_d;
      allow_q <= allow_d;
      gp_q <= cts_s2_q;
      cstop_q <= cstop_d;
      rstop_q <= rstop_d;
    end
  end

  // ----------------------------------------
  // port drive
  // ----------------------------------------
  assign int_out = int_out_q;
  assign int_oe = int_oe_q;
  assign tx_ready_n = txr_q;
  assign rx_ready_n = rxr_q;
  assign tx_ready_all_n = txr_all_q;
  assign rx_ready_all_n = rxr_all_q;
  assign data_out = byte_q;
  assign data_oe = byte_oe_q;
  assign serial_tx_out = tx_q;
  assign infrared_tx_out = ir_tx_q;
  assign rts_n_out = rts_q;
  assign dtr_n_out = dtr_q;
  assign cts_tx_allow = allow_q;
  assign cts_gp_n = gp_q;
  assign cts_stop_irq = cstop_q;
  assign rts_stop_irq = rstop_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_int_forced;
    @(posedge ref_clk) disable iff (rst)
      (bsel_s2_q && isel_s2_q) |=> (int_oe_q == 4'hF);
  endproperty
  a_int_forced: assert property (p_int_forced)
    else $error("interrupts not forced on");

  property p_int_bit3;
    @(posedge ref_clk) disable iff (rst)
      (!rst && bsel_s2_q && !isel_s2_q) |=> (int_oe_q == $past(int_en));
  endproperty
  a_int_bit3: assert property (p_int_bit3)
    else $error("interrupt enable not from bit3");

  property p_int_float;
    @(posedge ref_clk) disable iff (rst)
      (bsel_s2_q && !isel_s2_q && !int_en[0]) ##1 !int_en[0]
        |-> !int_oe_q[0];
  endproperty
  a_int_float: assert property (p_int_float)
    else $error("disabled interrupt still driven");

  property p_tx_rdy;
    @(posedge ref_clk) disable iff (rst)
      !rst |=> (tx_ready_n == ~$past(tx_space));
  endproperty
  a_tx_rdy: assert property (p_tx_rdy)
    else $error("tx ready not tracking space");

  property p_all_rdy;
    @(posedge ref_clk) disable iff (rst)
      (tx_ready_all_n == &tx_ready_n) && (rx_ready_all_n == &rx_ready_n);
  endproperty
  a_all_rdy: assert property (p_all_rdy)
    else $error("combined ready mismatch");

  property p_stat_byte;
    @(posedge ref_clk) disable iff (rst)
      !fss_s2_q |=> data_oe && (data_out == {rx_ready_n, ~tx_ready_n});
  endproperty
  a_stat_byte: assert property (p_stat_byte)
    else $error("status byte differs from pins");

  property p_tx_idle;
    @(posedge ref_clk) disable iff (rst)
      (!ir_en[0] && tx_serial[0]) |=> serial_tx_out[0];
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("plain tx not idling high");

  property p_ir_idle;
    @(posedge ref_clk) disable iff (rst)
      (!rst && ir_en[1] && !tx_ir_enc[1]) |=> !serial_tx_out[1];
  endproperty
  a_ir_idle: assert property (p_ir_idle)
    else $error("infrared tx not idling low");

  property p_cts_gate;
    @(posedge ref_clk) disable iff (rst)
      (!rst && enhanced_feature_reg[2][`QPSL_FEAT_ACTS] && cts_s2_q[2])
        |=> !cts_tx_allow[2];
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("cts high did not stop tx");

endmodule // qpsl_top

// File: sim/qpsl_far_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// far side: host strap wiring and line transceivers
// ----------------------------------------
module qpsl_far_model (
  // what the bench wants on the pins
  input wire logic bus_sel_in,
  input wire logic int_sel_req,
  input wire logic [3:0] cts_req_n,
  // pins seen by the block
  output logic interrupt_select_in,
  output logic [3:0] cts_n_pin,
  // receive lines, outside this block
  output logic [3:0] rx_line
);
  // far transmitters leave every receive line at its idle high level
  assign rx_line = 4'hF;
  // select forced low in rw-line mode; a pull-down would give the same level
  assign interrupt_select_in = bus_sel_in & int_sel_req;
  // transceiver passes the far end clear-to-send straight through
  assign cts_n_pin = cts_req_n;
endmodule // qpsl_far_model

// File: sim/qpsl_top_tb.sv
`timescale 1ns/100ps
`include "qpsl_defs.svh"
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: %s", $time, msg); end end
// ----------------------------------------
// random bench against a cycle model of the pin logic
// ----------------------------------------
module qpsl_top_tb;
  // design ports
  logic ref_clk = 1'b0, rst = 1'b1, bus_sel_in = 1'b1, interrupt_select_in, fifo_status_select_n = 1'b1;
  logic [3:0][7:0] modem_control_reg = '0, enhanced_feature_reg = '0, interrupt_enable_reg = '0;
  logic [3:0] ch_irq = '0, tx_space = '0, rx_avail = '0, tx_serial = '0, tx_ir_enc = '0, rts_halt = '0;
  logic [3:0] cts_n_pin, int_out, int_oe, tx_ready_n, rx_ready_n, serial_tx_out, infrared_tx_out;
  logic [3:0] rts_n_out, dtr_n_out, cts_tx_allow, cts_gp_n, cts_stop_irq, rts_stop_irq;
  logic tx_ready_all_n, rx_ready_all_n, data_oe;
  logic [7:0] data_out;
  // partner requests
  logic int_sel_req = 1'b0;
  logic [3:0] cts_req_n = 4'hF;
  // model state: pin sync stages {bus, select, status select, cts}
  logic [6:0] s1, s2;
  logic [3:0] e_int_out, e_int_oe, e_txr, e_rxr, e_stx, e_ir_tx, e_rts, e_dtr, e_allow, e_gp, e_rirq;
  // cts edge pulse and the previous synced cts level
  logic [3:0] e_cirq, s3;
  logic e_txa, e_rxa, e_doe, checking = 1'b0;
  logic [7:0] e_dout;
  logic [31:0] r;
  int seed = 36433, n_mismatch = 0, comparisons = 0, i;

  // free running clock
  always #4 ref_clk = ~ref_clk;

  qpsl_far_model u_qpsl_far_model (.bus_sel_in, .int_sel_req, .cts_req_n, .interrupt_select_in, .cts_n_pin,
    .rx_line());

  qpsl_top u_qpsl_top (.ref_clk, .rst, .bus_sel_in, .interrupt_select_in, .fifo_status_select_n,
    .modem_control_reg, .enhanced_feature_reg, .interrupt_enable_reg, .ch_irq, .tx_space, .rx_avail,
    .tx_serial, .tx_ir_enc, .rts_halt, .cts_n_pin, .int_out, .int_oe, .tx_ready_n, .rx_ready_n,
    .tx_ready_all_n, .rx_ready_all_n, .data_out, .data_oe, .serial_tx_out, .infrared_tx_out,
    .rts_n_out, .dtr_n_out, .cts_tx_allow, .cts_gp_n, .cts_stop_irq, .rts_stop_irq);

  // ----------------------------------------
  // stimulus: every input random each cycle
  // ----------------------------------------
  // pins change each cycle too; the model carries the same sync lag so no settling is needed
  always @(posedge ref_clk) begin
    r = $random(seed);
    modem_control_reg <= $random(seed);
    enhanced_feature_reg <= $random(seed);
    interrupt_enable_reg <= $random(seed);
    {ch_irq, tx_space, rx_avail, tx_serial} <= r[15:0];
    {tx_ir_enc, rts_halt, cts_req_n} <= r[27:16];
    // mostly split mode and status select idle, so both sides of each choice get time
    bus_sel_in <= r[28] | r[29];
    fifo_status_select_n <= r[30] | r[31];
    int_sel_req <= r[3] ^ r[17];
  end

  // ----------------------------------------
  // cycle model, reads inputs as sampled at the edge
  // ----------------------------------------
  // also wakes on the reset edge: a mid-run reset clears the pins at once
  always @(posedge ref_clk or posedge rst) begin
    checking = 1'b1;
    if (rst) begin
      s1 = 7'h5F;
      s2 = 7'h5F;
      s3 = 4'hF;
      {e_int_out, e_int_oe, e_txr, e_rxr, e_txa, e_rxa, e_doe, e_dout} = {8'h00, 8'hFF, 3'h6, 8'h00};
      {e_stx, e_ir_tx, e_rts, e_dtr, e_allow, e_gp, e_rirq, e_cirq} = 32'hF0FFFF00;
    end else begin
      e_txr = ~tx_space;
      e_rxr = ~rx_avail;
      e_txa = &e_txr;
      e_rxa = &e_rxr;
      // status byte only when the synced select is low
      e_doe = ~s2[4];
      e_dout = {e_rxr, ~e_txr};
      e_ir_tx = tx_ir_enc;
      e_gp = s2[3:0];
      for (i = 0; i < `QPSL_NCH; i++) begin
        e_stx[i] = modem_control_reg[i][`QPSL_MCTL_IR] ? tx_ir_enc[i] : tx_serial[i];
        e_dtr[i] = ~modem_control_reg[i][`QPSL_MCTL_DTR];
        e_rts[i] = ~(modem_control_reg[i][`QPSL_MCTL_RTS] & ~(enhanced_feature_reg[i][`QPSL_FEAT_ARTS] & rts_halt[i]));
        e_rirq[i] = enhanced_feature_reg[i][`QPSL_FEAT_ARTS] & rts_halt[i] &
                    interrupt_enable_reg[i][`QPSL_IEN_RTSI] & modem_control_reg[i][`QPSL_MCTL_RTS];
        e_allow[i] = ~(enhanced_feature_reg[i][`QPSL_FEAT_ACTS] & s2[i]);
        // one pulse per rising synced cts level while auto cts and its irq are on
        e_cirq[i] = enhanced_feature_reg[i][`QPSL_FEAT_ACTS] & interrupt_enable_reg[i][`QPSL_IEN_CTSI] &
                    s2[i] & ~s3[i];
        e_int_oe[i] = s2[5] | modem_control_reg[i][`QPSL_MCTL_INTEN];
      end
      // split mode: select high overrides the enable bits
      if (s2[6]) begin
        e_int_out = ch_irq;
      end else begin
        e_int_out = 4'h0;
        e_int_oe = {3'h7, |ch_irq};
      end
      s3 = s2[3:0];
      s2 = s1;
      s1 = {bus_sel_in, interrupt_select_in, fifo_status_select_n, cts_n_pin};
    end
  end

  // ----------------------------------------
  // compare at the falling edge, outputs settled
  // ----------------------------------------
  always @(negedge ref_clk) begin
    if (checking) begin
      `CHK(int_out, e_int_out, "interrupt level")
      `CHK(int_oe, e_int_oe, "interrupt enable")
      `CHK(tx_ready_n, e_txr, "tx ready")
      `CHK(rx_ready_n, e_rxr, "rx ready")
      `CHK(tx_ready_all_n, e_txa, "tx ready all")
      `CHK(rx_ready_all_n, e_rxa, "rx ready all")
      `CHK(data_oe, e_doe, "status enable")
      // byte content only meaningful while driven
      if (e_doe) `CHK(data_out, e_dout, "status byte")
      `CHK(serial_tx_out, e_stx, "serial tx")
      `CHK(infrared_tx_out, e_ir_tx, "infrared tx")
      `CHK(rts_n_out, e_rts, "request to send")
      `CHK(rts_stop_irq, e_rirq, "rts irq")
      `CHK(cts_tx_allow, e_allow, "cts allow")
      `CHK(cts_gp_n, e_gp, "cts level")
      `CHK(cts_stop_irq, e_cirq, "cts irq")
      `CHK(dtr_n_out, e_dtr, "terminal ready")
    end
  end

  // verdict and end of run
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence: reset, random run, mid-run reset, run
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2000) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2000) @(posedge ref_clk);
    complete_run();
  end
endmodule // qpsl_top_tb
